/* design/spims_pkg.sv */
package spims_pkg;
	localparam int          SPIMS_BITS          = 8;
	localparam logic [2:0]  SPIMS_BIT_LAST      = 3'h7;
	localparam logic [3:0]  SPIMS_PULSES        = 4'h8;
	localparam logic [7:0]  SPIMS_DATA_RESET    = 8'h00;
	// half-period of the master clock in ref_clk cycles, per rate select code
	localparam logic [6:0]  SPIMS_HALF_DIV0     = 7'h01;
	localparam logic [6:0]  SPIMS_HALF_DIV1     = 7'h04;
	localparam logic [6:0]  SPIMS_HALF_DIV2     = 7'h10;
	localparam logic [6:0]  SPIMS_HALF_DIV3     = 7'h20;

	typedef enum logic [1:0] {
		SPIMS_IDLE  = 2'b00,
		SPIMS_SHIFT = 2'b01,
		SPIMS_DONE  = 2'b10
	} spims_state_t;
endpackage

/* design/spims_core.sv */
`timescale 1ns/10ps
module spims_core
	import spims_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       ctrl_wr,
	input  wire logic [7:0] ctrl_wdata,
	input  wire logic       status_rd,
	input  wire logic       data_wr,
	input  wire logic [7:0] data_wdata,
	input  wire logic       data_rd,
	input  wire logic       cpu_irq_mask,
	input  wire logic       sck_in,
	input  wire logic       mosi_in,
	input  wire logic       miso_in,
	input  wire logic       ss_n_in,
	output logic            sck_out,
	output logic            sck_oe_n,
	output logic            mosi_out,
	output logic            mosi_oe_n,
	output logic            miso_out,
	output logic            miso_oe_n,
	output logic [7:0]      ctrl_rdata,
	output logic [7:0]      data_rdata,
	output logic            transfer_done_flag,
	output logic            write_collision_flag,
	output logic            irq
);
	// control bits: 7 done_irq_enable, 6 port_enable, 4 master_select,
	// 3 polarity, 2 phase, 1 rate_select_hi, 0 rate_select_lo
	logic       done_irq_enable_q, port_enable_q, master_select_q;
	logic       cpol_q, cpha_q;
	logic [1:0] rate_q;
	logic [1:0] sck_s_q, mosi_s_q, miso_s_q, ss_s_q;
	logic       sck_prev_q;
	spims_state_t state_q;
	logic [7:0] shift_q;
	logic [7:0] rx_buf_q;
	logic [7:0] tx_q;
	logic       tx_bit_q;
	logic [3:0] pul_q;
	logic [3:0] rx_n_q;
	logic [2:0] cap_dly_q;
	logic       edge_odd_q;
	logic [6:0] div_q;
	logic       msck_q;
	logic       done_q, write_collision_flag_q, done_seen_q, write_collision_flag_seen_q;

	function automatic logic [6:0] half_div(input logic [1:0] sel);
		unique case (sel)
			2'h0: half_div = SPIMS_HALF_DIV0;
			2'h1: half_div = SPIMS_HALF_DIV1;
			2'h2: half_div = SPIMS_HALF_DIV2;
			2'h3: half_div = SPIMS_HALF_DIV3;
		endcase
	endfunction

	// pins from outside pass two flops before use
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sck_s_q  <= 2'h0;
			mosi_s_q <= 2'h0;
			miso_s_q <= 2'h0;
			ss_s_q   <= 2'h3;
		end else begin
			sck_s_q  <= {sck_s_q[0], sck_in};
			mosi_s_q <= {mosi_s_q[0], mosi_in};
			miso_s_q <= {miso_s_q[0], miso_in};
			ss_s_q   <= {ss_s_q[0], ss_n_in};
		end
	end

	logic ss_n, sck_sync, rx_bit, active, slave_sel, sck_edge, dr_ok;
	assign ss_n      = ss_s_q[1];
	assign sck_sync  = sck_s_q[1];
	assign rx_bit    = master_select_q ? miso_s_q[1] : mosi_s_q[1];
	assign active    = (state_q == SPIMS_SHIFT);
	assign slave_sel = port_enable_q && !master_select_q && !ss_n;
	// write accepted only when idle and done flag low
	assign dr_ok     = data_wr && !done_q && !active && port_enable_q
		&& (master_select_q || ss_n);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_irq_enable_q <= 1'b0;
			port_enable_q     <= 1'b0;
			master_select_q   <= 1'b0;
			cpol_q            <= 1'b0;
			cpha_q            <= 1'b0;
			rate_q            <= 2'h0;
		end else begin
			if (ctrl_wr) begin
				done_irq_enable_q <= ctrl_wdata[7];
				port_enable_q     <= ctrl_wdata[6];
				master_select_q   <= ctrl_wdata[4];
				cpol_q            <= ctrl_wdata[3];
				cpha_q            <= ctrl_wdata[2];
				rate_q            <= ctrl_wdata[1:0];
			end
			// a master whose select is pulled low gives up the bus
			if (master_select_q && !ss_n) begin
				port_enable_q   <= 1'b0;
				master_select_q <= 1'b0;
			end
		end
	end

	// slave edge detector reads only the second synchroniser stage
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			sck_prev_q <= 1'b0;
		else
			sck_prev_q <= sck_sync;
	end

	// master clock generator: only runs during a transfer
	// the clock parks at its idle level once all pulses are out
	logic mtick, mrun;
	assign mrun  = master_select_q && active && (pul_q != SPIMS_PULSES);
	assign mtick = mrun && (div_q == 7'h00);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q  <= 7'h00;
			msck_q <= 1'b0;
		end else if (!mrun) begin
			div_q  <= half_div(rate_q) - 7'h01;
			msck_q <= cpol_q;
		end else if (div_q == 7'h00) begin
			div_q  <= half_div(rate_q) - 7'h01;
			msck_q <= !msck_q;
		end else begin
			div_q <= div_q - 7'h01;
		end
	end

	// slave uses received edges; rate bits are not consulted here
	assign sck_edge = master_select_q ? mtick
		: (slave_sel && (sck_sync != sck_prev_q));

	// edge_odd_q is low ahead of a pulse's leading edge, high ahead of its
	// trailing edge; capture on the leading edge when phase is clear
	logic capture, launch, start, take, last;
	assign capture = sck_edge && (edge_odd_q == cpha_q);
	assign launch  = sck_edge && (edge_odd_q != cpha_q);
	assign start   = (state_q == SPIMS_IDLE) && slave_sel && sck_edge;
	// the master's miso passes the synchroniser, so its capture is taken three
	// cycles late; the far end holds the bit that long even at the fastest rate
	assign take    = master_select_q ? cap_dly_q[2] : capture;
	assign last    = (pul_q == SPIMS_PULSES) && (rx_n_q == SPIMS_PULSES);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q  <= SPIMS_IDLE;
			rx_buf_q <= SPIMS_DATA_RESET;
		end else begin
			unique case (state_q)
				SPIMS_IDLE: begin
					if (dr_ok && master_select_q)
						state_q <= SPIMS_SHIFT;
					else if (start)
						state_q <= SPIMS_SHIFT;
				end
				SPIMS_SHIFT: begin
					if (!port_enable_q || (!master_select_q && ss_n))
						state_q <= SPIMS_IDLE;
					else if (last)
						state_q <= SPIMS_DONE;
				end
				SPIMS_DONE: begin
					rx_buf_q <= shift_q;
					state_q  <= SPIMS_IDLE;
				end
				default: state_q <= SPIMS_IDLE;
			endcase
		end
	end

	// pulse counter: a pulse ends on its trailing edge
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			edge_odd_q <= 1'b0;
			pul_q      <= 4'h0;
		end else if ((state_q == SPIMS_IDLE) && !start) begin
			edge_odd_q <= 1'b0;
			pul_q      <= 4'h0;
		end else if (sck_edge) begin
			edge_odd_q <= !edge_odd_q;
			if (edge_odd_q)
				pul_q <= pul_q + 4'h1;
		end
	end

	// transmit side: with phase clear the msb already stands before the first
	// edge, so the loaded copy skips it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_q     <= SPIMS_DATA_RESET;
			tx_bit_q <= 1'b0;
		end else if ((state_q == SPIMS_IDLE) && dr_ok) begin
			tx_q     <= cpha_q ? data_wdata : {data_wdata[6:0], 1'b0};
			tx_bit_q <= data_wdata[7];
		end else if (launch) begin
			tx_bit_q <= tx_q[7];
			tx_q     <= {tx_q[6:0], 1'b0};
		end
	end

	// receive side
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_q   <= SPIMS_DATA_RESET;
			rx_n_q    <= 4'h0;
			cap_dly_q <= 3'h0;
		end else begin
			cap_dly_q <= {cap_dly_q[1:0], master_select_q && capture};
			if ((state_q == SPIMS_IDLE) && !start) begin
				rx_n_q <= 4'h0;
			end else if (take) begin
				shift_q <= {shift_q[6:0], rx_bit};
				rx_n_q  <= rx_n_q + 4'h1;
			end
		end
	end

	// done and collision flags: set wins over the clearing sequence
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_q      <= 1'b0;
			done_seen_q <= 1'b0;
			write_collision_flag_q      <= 1'b0;
			write_collision_flag_seen_q <= 1'b0;
		end else begin
			if (state_q == SPIMS_DONE) begin
				done_q      <= 1'b1;
				done_seen_q <= 1'b0;
			end else if (done_seen_q && (data_rd || data_wr)) begin
				done_q      <= 1'b0;
				done_seen_q <= 1'b0;
			end else if (status_rd && done_q) begin
				done_seen_q <= 1'b1;
			end
			if (data_wr && (active || (!master_select_q && !ss_n && port_enable_q)))
				write_collision_flag_q <= 1'b1;
			else if (write_collision_flag_seen_q && (data_rd || data_wr))
				write_collision_flag_q <= 1'b0;
			if (status_rd && write_collision_flag_q)
				write_collision_flag_seen_q <= 1'b1;
			else if (!write_collision_flag_q)
				write_collision_flag_seen_q <= 1'b0;
		end
	end
	// registered pin and status outputs
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sck_out              <= 1'b0;
			sck_oe_n             <= 1'b1;
			mosi_out             <= 1'b0;
			mosi_oe_n            <= 1'b1;
			miso_out             <= 1'b0;
			miso_oe_n            <= 1'b1;
			ctrl_rdata           <= 8'h00;
			data_rdata           <= SPIMS_DATA_RESET;
			transfer_done_flag   <= 1'b0;
			write_collision_flag <= 1'b0;
			irq                  <= 1'b0;
		end else begin
			sck_out   <= msck_q;
			sck_oe_n  <= !(port_enable_q && master_select_q);
			mosi_out  <= tx_bit_q;
			mosi_oe_n <= !(port_enable_q && master_select_q);
			miso_out  <= tx_bit_q;
			miso_oe_n <= !slave_sel;
			ctrl_rdata <= {done_irq_enable_q, port_enable_q, 1'b0, master_select_q,
				cpol_q, cpha_q, rate_q};
			data_rdata           <= rx_buf_q;
			transfer_done_flag   <= done_q;
			write_collision_flag <= write_collision_flag_q;
			irq <= done_q && done_irq_enable_q && !cpu_irq_mask;
		end
	end
endmodule

/* tb/spims_chk.sv */
`timescale 1ns/10ps
module spims_chk (
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic       ss_n_in,
	input wire logic       data_wr,
	input wire logic       data_rd,
	input wire logic       sck_out,
	input wire logic       sck_oe_n,
	input wire logic       miso_oe_n,
	input wire logic [7:0] ctrl_rdata,
	input wire logic       transfer_done_flag,
	input wire logic       irq
);
	logic [2:0] acc_q;
	wire logic  mst = ctrl_rdata[6] && ctrl_rdata[4];
	// the flag output lags the data access by up to three edges
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			acc_q <= 3'h0;
		else
			acc_q <= {acc_q[1:0], data_rd || data_wr};
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_ss_low; !ss_n_in && mst; endsequence
	sequence s_desel; ss_n_in [*5]; endsequence
	property p_irq; irq |-> transfer_done_flag && ctrl_rdata[7]; endproperty
	property p_rst; $rose(rst_n) |-> !transfer_done_flag && sck_oe_n && miso_oe_n; endproperty
	property p_clr; $fell(transfer_done_flag) |-> acc_q != 3'h0; endproperty
	property p_idle; transfer_done_flag && !sck_oe_n |-> sck_out == ctrl_rdata[3]; endproperty
	property p_msck; mst |-> ##[0:2] !sck_oe_n; endproperty
	property p_ssck; !ctrl_rdata[4] |-> ##[0:2] sck_oe_n; endproperty
	property p_ss; s_ss_low |-> ##[1:6] !ctrl_rdata[4] && !ctrl_rdata[6]; endproperty
	property p_desel; s_desel |-> miso_oe_n; endproperty
	a_irq: assert property (p_irq) else $error("irq without done flag and enable");
	a_rst: assert property (p_rst) else $error("port active after reset");
	a_clr: assert property (p_clr) else $error("done flag fell without data access");
	a_idle: assert property (p_idle) else $error("idle clock level wrong");
	a_msck: assert property (p_msck) else $error("master not driving clock");
	a_ssck: assert property (p_ssck) else $error("slave driving clock pin");
	a_ss: assert property (p_ss) else $error("master kept with select low");
	a_desel: assert property (p_desel) else $error("deselected slave drives miso");
endmodule
bind spims_core spims_chk spims_chk_i (.ref_clk(ref_clk), .rst_n(rst_n), .ss_n_in(ss_n_in),
	.data_wr(data_wr), .data_rd(data_rd), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
	.miso_oe_n(miso_oe_n), .ctrl_rdata(ctrl_rdata), .transfer_done_flag(transfer_done_flag),
	.irq(irq));

/* tb/spims_peer.sv */
`timescale 1ns/10ps
module spims_peer (
	input wire logic       sck,
	input wire logic       mosi,
	input wire logic       cpol,
	input wire logic       cpha,
	input wire logic       ld,
	input wire logic [7:0] tx,
	output logic           miso,
	output logic [7:0]     rx,
	output logic [7:0]     edges
);
	logic [7:0] sh;
	always @(posedge ld) begin
		sh = cpha ? tx : {tx[6:0], 1'b0};
		miso = cpha ? ~tx[7] : tx[7];
		edges = 8'h00;
	end
	// capture on leading edge with phase clear, trailing edge with phase set
	always @(sck) begin
		edges = edges + 8'h01;
		if (sck ^ cpol ^ cpha)
			rx = {rx[6:0], mosi};
		else begin
			miso = sh[7];
			sh = {sh[6:0], ~sh[0]};
		end
	end
endmodule

/* tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
	import spims_pkg::*;
	logic       ref_clk, rst_n, ctrl_wr, status_rd, data_wr, data_rd, cpu_irq_mask;
	logic       sck_tb, mosi_tb, ss_n_in, ld, cpol, cpha;
	logic [7:0] ctrl_wdata, data_wdata, ptx;
	logic       sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, miso_in;
	logic       transfer_done_flag, write_collision_flag, irq;
	logic [7:0] ctrl_rdata, data_rdata, prx, edges;
	int         err_count, comparisons;
	wire logic  sck_in = sck_oe_n ? sck_tb : sck_out;
	wire logic  mosi_in = mosi_oe_n ? mosi_tb : mosi_out;
	spims_core spims_core_i (.ref_clk, .rst_n, .ctrl_wr, .ctrl_wdata, .status_rd, .data_wr,
		.data_wdata, .data_rd, .cpu_irq_mask, .sck_in, .mosi_in, .miso_in, .ss_n_in, .sck_out,
		.sck_oe_n, .mosi_out, .mosi_oe_n, .miso_out, .miso_oe_n, .ctrl_rdata, .data_rdata,
		.transfer_done_flag, .write_collision_flag, .irq);
	spims_peer spims_peer_i (.sck(sck_in), .mosi(mosi_in), .cpol, .cpha, .ld, .tx(ptx),
		.miso(miso_in), .rx(prx), .edges);
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] d, input logic c);
		@(negedge ref_clk);
		ctrl_wr = c;
		data_wr = !c;
		ctrl_wdata = d;
		data_wdata = d;
		@(negedge ref_clk);
		ctrl_wr = 1'b0;
		data_wr = 1'b0;
	endtask
	task automatic clr();
		@(negedge ref_clk) status_rd = 1'b1;
		@(negedge ref_clk) status_rd = 1'b0;
		data_rd = 1'b1;
		@(negedge ref_clk) data_rd = 1'b0;
		repeat (3) @(negedge ref_clk);
	endtask
	task automatic wdone(output int n);
		n = 0;
		while (transfer_done_flag !== 1'b1 && n < 3000) begin
			@(negedge ref_clk);
			n++;
		end
		repeat (2) @(negedge ref_clk);
	endtask
	task automatic t_master();
		int         n;
		logic [6:0] h [4] = '{SPIMS_HALF_DIV0, SPIMS_HALF_DIV1, SPIMS_HALF_DIV2, SPIMS_HALF_DIV3};
		for (int i = 0; i < 4; i++) begin
			cpol = i[1];
			cpha = i[0];
			cpu_irq_mask = (i == 3);
			wr({4'hD, 2'(i), 2'(i)}, 1'b1);
			repeat (4) @(negedge ref_clk);
			ptx = 8'h5A ^ 8'(i);
			ld = 1'b1;
			#1 ld = 1'b0;
			wr(8'hC3 + 8'(i), 1'b0);
			wdone(n);
			chk({7'h0, n >= 16 * h[i] && n <= 16 * h[i] + 12}, 8'h01);
			chk(data_rdata, ptx);
			chk(prx, 8'hC3 + 8'(i));
			chk(edges, 8'h10);
			chk({6'h0, irq, sck_out}, {6'h0, i != 3, cpol});
			clr();
			chk({7'h0, transfer_done_flag}, 8'h00);
		end
	endtask
	task automatic t_coll();
		int n;
		wr(8'h96, 1'b0);
		repeat (6) @(negedge ref_clk);
		wr(8'h11, 1'b0);
		wdone(n);
		chk({6'h0, write_collision_flag, transfer_done_flag}, 8'h03);
		chk(prx, 8'h96);
		wr(8'h22, 1'b0);
		repeat (40) @(negedge ref_clk);
		chk(prx, 8'h96);
		clr();
		chk({6'h0, write_collision_flag, transfer_done_flag}, 8'h00);
	endtask
	task automatic t_ss();
		ss_n_in = 1'b0;
		repeat (8) @(negedge ref_clk);
		chk(ctrl_rdata & 8'h50, 8'h00);
		ss_n_in = 1'b1;
	endtask
	task automatic t_slave();
		int         n;
		logic [7:0] got;
		logic [7:0] m = 8'hA5;
		wr(8'h43, 1'b1);
		wr(8'h3C, 1'b0);
		@(negedge ref_clk) ss_n_in = 1'b0;
		// slow external clock keeps well inside the synchroniser margin
		for (int b = 7; b >= 0; b--) begin
			mosi_tb = m[b];
			repeat (8) @(negedge ref_clk);
			got[b] = miso_out;
			sck_tb = 1'b1;
			repeat (8) @(negedge ref_clk);
			sck_tb = 1'b0;
		end
		wdone(n);
		chk(data_rdata, 8'hA5);
		chk(got, 8'h3C);
		ss_n_in = 1'b1;
		repeat (8) @(negedge ref_clk);
		chk({7'h0, miso_oe_n}, 8'h01);
	endtask
	task automatic end_of_test();
		$display("comparisons=%0d err_count=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		{err_count, comparisons} = '0;
		{rst_n, ctrl_wr, status_rd, data_wr, data_rd, cpu_irq_mask} = '0;
		{sck_tb, mosi_tb, ld, cpol, cpha, ctrl_wdata, data_wdata, ptx} = '0;
		ss_n_in = 1'b1;
		repeat (2) @(negedge ref_clk);
		rst_n = 1'b1;
		@(negedge ref_clk);
		chk({ctrl_rdata[6], transfer_done_flag, sck_oe_n, mosi_oe_n, miso_oe_n, 3'h0}, 8'h38);
		t_master();
		t_coll();
		t_ss();
		t_slave();
		end_of_test();
	end
	// full run is near 1700 cycles
	initial begin
		#40000;
		err_count++;
		end_of_test();
	end
endmodule
